// >>> rtl/rsq_pkg.sv
// package: constants, field layout and states of the readout instruction sequencer
package rsq_pkg;
  // register byte addresses on the wishbone slave
  localparam logic [15:0] REG_CTRL = 16'h0000;
  localparam logic [15:0] REG_STATUS = 16'h0004;
  localparam logic [15:0] REG_PRANGE = 16'h0008;
  localparam logic [15:0] IMEM_BASE = 16'h0400;
  localparam logic [15:0] IMEM_LAST = 16'h07FC;
  localparam logic [15:0] PMEM_BASE = 16'h1000;
  localparam logic [15:0] PMEM_LAST = 16'h1FFC;
  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_HI = 2;
  // partial range register fields
  localparam int PR_FIRST_LO = 0;
  localparam int PR_LAST_LO = 16;
  // instruction word fields
  localparam int INS_CHIP = 22;
  localparam int INS_WRITE = 21;
  localparam int INS_HALF = 20;
  localparam int INS_CODE_LO = 16;
  localparam int PED_BCAST = 15;
  localparam int PED_BLOCK = 14;
  localparam int JMP_JNL = 15;
  localparam int JMP_N_LO = 8;
  // macro codes
  localparam logic [3:0] OP_JUMP = 4'h0;
  localparam logic [3:0] OP_PED_WRITE = 4'h8;
  localparam logic [3:0] OP_END = 4'h9;
  localparam logic [3:0] OP_WAIT = 4'hA;
  localparam logic [3:0] OP_TRIGGER = 4'hB;
  // trigger running modes
  localparam logic [1:0] MODE_SOFT = 2'h0;
  localparam logic [1:0] MODE_L1 = 2'h2;
  localparam logic [1:0] MODE_L1L2 = 2'h3;
  // pedestal memory span
  localparam logic [9:0] PED_FIRST_FULL = 10'h000;
  localparam logic [9:0] PED_LAST_FULL = 10'h3FF;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b011,
    ST_PED_ADDR = 3'b100,
    ST_PED_DATA = 3'b101
  } rsq_state_e;
endpackage : rsq_pkg

// >>> rtl/rsq_sequencer.sv
// readout instruction sequencer with wishbone register slave and trigger mode logic
// Contract
// - pedestal write macro sends address then data command; full memory covers 1024 locations
// - block flag set limits the transfer to the configured partial range
// - broadcast flag set sends the pedestal write to every channel
// - macro carries a 12-bit channel address selecting the target channel
// - end instruction stops fetching, leaves busy; nothing after it runs
// - wait instruction holds the pointer for the hold-count plus one cycles, then continues
// - trigger instruction makes a first level trigger, handled like an external one in mode 2 only
// - mode 0 default accepts only soft triggers issued inside a sequence
// - mode 2 starts an event on one first level trigger, external or internal
// - mode 3 needs external first level trigger then second level accept or reject
// - exactly three trigger modes chosen by configuration, mode 0 after reset
// - 24-bit instructions: chip/macro, write, half, 4-bit code, 16-bit data
// - jump always when flag clear; loop while call count at most N
`timescale 1ns/1ps
`default_nettype none
module rsq_sequencer #(
  parameter int IMEM_AW = 8,
  parameter logic [4:0] PED_ADDR_CMD = 5'h06,
  parameter logic [4:0] PED_DATA_CMD = 5'h07,
  parameter logic [4:0] SOFT_TRIG_CMD = 5'h1B
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_ready_i,
  output logic bus_valid_o,
  output logic bus_write_o,
  output logic bus_bcast_o,
  output logic [39:0] bus_word_o,
  input wire logic ext_l1_i,
  input wire logic second_level_accept_i,
  input wire logic second_level_reject_i,
  output logic first_level_trigger_o,
  output logic event_start_o,
  output logic event_accept_o,
  output logic event_reject_o,
  output logic busy_o
);
  import rsq_pkg::*;
  logic [23:0] imem [0:(1<<IMEM_AW)-1];
  logic [19:0] pmem [0:1023];
  rsq_state_e state, next_state;
  logic [IMEM_AW-1:0] pc, next_pc, loop_pc, next_loop_pc;
  logic [6:0] loop_cnt, next_loop_cnt;
  logic [23:0] instr, next_instr;
  logic [15:0] wait_cnt, next_wait_cnt;
  logic [9:0] ped_idx, next_ped_idx, ped_last, next_ped_last;
  logic [19:0] first_half, next_first_half;
  logic [1:0] mode, next_mode;
  logic [9:0] pr_first, next_pr_first, pr_last, next_pr_last;
  logic next_busy, next_valid, next_write, next_bcast, next_l1, next_ack, start_req;
  logic [39:0] next_word;
  logic soft_trig, next_soft_trig, l2_wait, next_l2_wait, next_start_ev, next_acc_ev, next_rej_ev;
  logic [31:0] next_rdata;
  logic wb_req, wb_wr, imem_we, pmem_we, stall;
  // word index of a byte address inside a memory window
  function automatic logic [9:0] word_index(input logic [15:0] adr, input logic [15:0] base);
    return 10'((adr - base) >> 2);
  endfunction : word_index
  // word placed on the 40-bit bus for one pedestal step
  function automatic logic [39:0] ped_word(input logic bc, input logic [11:0] ch,
                                           input logic [4:0] cmd, input logic [19:0] dat);
    return {1'b0, bc, ch, cmd, 1'b0, dat};
  endfunction : ped_word
  // wishbone decode; ack one cycle after request and dropped the cycle after
  always_comb begin
    wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wb_wr = wb_req && wb_we_i;
    start_req = 1'b0;
    imem_we = 1'b0;
    pmem_we = 1'b0;
    next_ack = wb_req;
    next_rdata = 32'h0000_0000;
    next_mode = mode;
    next_pr_first = pr_first;
    next_pr_last = pr_last;
    if (wb_adr_i == REG_CTRL) begin
      next_rdata = {29'h0000_0000, mode, 1'b0};
      if (wb_wr && wb_sel_i[0]) begin
        start_req = wb_dat_i[CTRL_START];
        if (wb_dat_i[CTRL_MODE_HI:CTRL_MODE_LO] != 2'h1) begin // mode 1 unused: keep old mode
          next_mode = wb_dat_i[CTRL_MODE_HI:CTRL_MODE_LO];
        end
      end
    end else if (wb_adr_i == REG_STATUS) begin
      next_rdata = {15'h0000, busy_o, 3'h0, l2_wait, 4'h0, 8'(pc)};
    end else if (wb_adr_i == REG_PRANGE) begin
      next_rdata = {6'h00, pr_last, 6'h00, pr_first};
      if (wb_wr) begin
        next_pr_first = wb_dat_i[PR_FIRST_LO +: 10];
        next_pr_last = wb_dat_i[PR_LAST_LO +: 10];
      end
    end else if (wb_adr_i >= IMEM_BASE && wb_adr_i <= IMEM_LAST) begin
      next_rdata = {8'h00, imem[IMEM_AW'(word_index(wb_adr_i, IMEM_BASE))]};
      imem_we = wb_wr;
    end else if (wb_adr_i >= PMEM_BASE && wb_adr_i <= PMEM_LAST) begin
      next_rdata = {12'h000, pmem[word_index(wb_adr_i, PMEM_BASE)]};
      pmem_we = wb_wr;
    end
    if (!wb_req || wb_we_i) begin
      next_rdata = 32'h0000_0000;
    end
  end
  // memories are loaded only through the slave; the sequencer reads them
  always_ff @(posedge clk_i) begin
    if (imem_we) begin
      imem[IMEM_AW'(word_index(wb_adr_i, IMEM_BASE))] <= wb_dat_i[23:0];
    end
    if (pmem_we) begin
      pmem[word_index(wb_adr_i, PMEM_BASE)] <= wb_dat_i[19:0];
    end
  end
  // sequencer next state; a word not yet taken by the bus freezes everything
  always_comb begin
    stall = bus_valid_o && !bus_ready_i;
    next_state = state;
    next_pc = pc;
    next_loop_pc = loop_pc;
    next_loop_cnt = loop_cnt;
    next_instr = instr;
    next_wait_cnt = wait_cnt;
    next_ped_idx = ped_idx;
    next_ped_last = ped_last;
    next_first_half = first_half;
    next_busy = busy_o;
    next_valid = stall;
    next_write = bus_write_o;
    next_bcast = bus_bcast_o && (stall || state == ST_PED_DATA);
    next_word = bus_word_o;
    next_l1 = 1'b0;
    next_soft_trig = 1'b0;
    if (!stall) begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            next_busy = 1'b1;
            next_pc = '0;
            next_loop_cnt = '0;
            next_state = ST_FETCH;
          end
        end
        ST_FETCH: begin
          next_instr = imem[pc];
          next_state = ST_EXEC;
        end
        ST_EXEC: begin
          next_pc = pc + 1'b1;
          next_state = ST_FETCH;
          if (instr[INS_CHIP]) begin
            if (!instr[INS_HALF] && instr[INS_WRITE]) begin
              next_first_half = instr[19:0];
            end else begin
              next_valid = 1'b1;
              next_write = instr[INS_WRITE];
              next_bcast = 1'b0;
              next_word = {instr[INS_WRITE] ? first_half : 20'h00000, instr[19:0]};
              next_first_half = 20'h00000;
              next_soft_trig = !instr[INS_WRITE] && instr[4:0] == SOFT_TRIG_CMD;
            end
          end else begin
            case (instr[INS_CODE_LO +: 4])
              OP_JUMP: begin
                if (!instr[JMP_JNL]) begin
                  next_pc = instr[IMEM_AW-1:0];
                end else begin
                  // the count belongs to this loop instruction only
                  next_loop_cnt = (loop_pc == pc) ? loop_cnt + 1'b1 : 7'h01;
                  next_loop_pc = pc;
                  if (next_loop_cnt <= instr[JMP_N_LO +: 7]) begin
                    next_pc = instr[IMEM_AW-1:0];
                  end else begin
                    next_loop_cnt = '0;
                  end
                end
              end
              OP_PED_WRITE: begin
                next_pc = pc;
                if (instr[PED_BLOCK]) begin
                  next_ped_idx = pr_first;
                  next_ped_last = pr_last;
                end else begin
                  next_ped_idx = PED_FIRST_FULL;
                  next_ped_last = PED_LAST_FULL;
                end
                next_state = ST_PED_ADDR;
              end
              OP_END: begin
                next_pc = pc;
                next_busy = 1'b0;
                next_state = ST_IDLE;
              end
              OP_WAIT: begin
                next_pc = pc;
                next_wait_cnt = instr[15:0];
                next_state = ST_WAIT;
              end
              OP_TRIGGER: begin
                next_l1 = 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        ST_WAIT: begin
          if (wait_cnt == 16'h0000) begin
            next_pc = pc + 1'b1;
            next_state = ST_FETCH;
          end else begin
            next_wait_cnt = wait_cnt - 1'b1;
          end
        end
        ST_PED_ADDR: begin
          next_valid = 1'b1;
          next_write = 1'b1;
          next_bcast = instr[PED_BCAST];
          next_word = ped_word(instr[PED_BCAST], instr[11:0], PED_ADDR_CMD,
                               {10'h000, ped_idx});
          next_state = ST_PED_DATA;
        end
        ST_PED_DATA: begin
          next_valid = 1'b1;
          next_word = ped_word(instr[PED_BCAST], instr[11:0], PED_DATA_CMD,
                               pmem[ped_idx]);
          if (ped_idx == ped_last) begin
            next_pc = pc + 1'b1;
            next_state = ST_FETCH;
          end else begin
            next_ped_idx = ped_idx + 1'b1;
            next_state = ST_PED_ADDR;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end
  // trigger running modes turn triggers into event pulses
  always_comb begin
    next_start_ev = 1'b0;
    next_acc_ev = 1'b0;
    next_rej_ev = 1'b0;
    next_l2_wait = 1'b0;
    case (mode)
      MODE_SOFT: begin
        next_start_ev = soft_trig;
      end
      MODE_L1: begin
        next_start_ev = ext_l1_i || first_level_trigger_o;
      end
      MODE_L1L2: begin
        // internal triggers are not enough here; the external one opens the event
        next_l2_wait = l2_wait;
        if (!l2_wait) begin
          next_start_ev = ext_l1_i;
          next_l2_wait = ext_l1_i;
        end else if (second_level_accept_i) begin
          next_acc_ev = 1'b1;
          next_l2_wait = 1'b0;
        end else if (second_level_reject_i) begin
          next_rej_ev = 1'b1;
          next_l2_wait = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end
  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      pc <= '0;
      loop_pc <= '0;
      loop_cnt <= '0;
      instr <= 24'h000000;
      wait_cnt <= 16'h0000;
      ped_idx <= 10'h000;
      ped_last <= 10'h000;
      first_half <= 20'h00000;
      busy_o <= 1'b0;
      bus_valid_o <= 1'b0;
      bus_write_o <= 1'b0;
      bus_bcast_o <= 1'b0;
      bus_word_o <= 40'h00_0000_0000;
      first_level_trigger_o <= 1'b0;
      soft_trig <= 1'b0;
      l2_wait <= 1'b0;
      event_start_o <= 1'b0;
      event_accept_o <= 1'b0;
      event_reject_o <= 1'b0;
      mode <= MODE_SOFT;
      pr_first <= 10'h000;
      pr_last <= 10'h000;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      state <= next_state;
      pc <= next_pc;
      loop_pc <= next_loop_pc;
      loop_cnt <= next_loop_cnt;
      instr <= next_instr;
      wait_cnt <= next_wait_cnt;
      ped_idx <= next_ped_idx;
      ped_last <= next_ped_last;
      first_half <= next_first_half;
      busy_o <= next_busy;
      bus_valid_o <= next_valid;
      bus_write_o <= next_write;
      bus_bcast_o <= next_bcast;
      bus_word_o <= next_word;
      first_level_trigger_o <= next_l1;
      soft_trig <= next_soft_trig;
      l2_wait <= next_l2_wait;
      event_start_o <= next_start_ev;
      event_accept_o <= next_acc_ev;
      event_reject_o <= next_rej_ev;
      mode <= next_mode;
      pr_first <= next_pr_first;
      pr_last <= next_pr_last;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end
endmodule : rsq_sequencer
`default_nettype wire

// >>> tb/rsq_fe_model.sv
// front-end partner: takes bus words, optionally stalling every other cycle
`timescale 1ns/1ps
`default_nettype none
module rsq_fe_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic bus_valid_i,
  input wire logic [39:0] bus_word_i,
  output logic ready_o
);
  logic [39:0] words[$];
  // toggling ready exercises the stall path of the sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) ready_o <= 1'b0;
    else ready_o <= slow_i ? !ready_o : 1'b1;
    if (!rst_i && bus_valid_i && ready_o) words.push_back(bus_word_i);
  end
endmodule : rsq_fe_model
`default_nettype wire

// >>> tb/rsq_monitor.sv
// checker: bus protocol and sequencing assertions for the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rsq_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic bus_ready_i,
  input wire logic bus_valid_o,
  input wire logic bus_write_o,
  input wire logic bus_bcast_o,
  input wire logic [39:0] bus_word_o,
  input wire logic first_level_trigger_o,
  input wire logic event_accept_o,
  input wire logic event_reject_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // one wait state, then a single-cycle ack
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("wishbone request not acknowledged");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // a stalled word must not move under the front end
  a_bus_hold: assert property (bus_valid_o && !bus_ready_i |=> bus_valid_o && $stable(bus_word_o))
    else $error("bus word changed while stalled");
  a_bcast_write: assert property (bus_bcast_o |-> bus_valid_o && bus_write_o && bus_word_o[38])
    else $error("broadcast not a marked write");
  a_trig_pulse: assert property (first_level_trigger_o |=> !first_level_trigger_o)
    else $error("trigger pulse too long");
  a_trig_busy: assert property (first_level_trigger_o |-> $past(busy_o))
    else $error("trigger outside a sequence");
  a_l2_excl: assert property (!(event_accept_o && event_reject_o))
    else $error("accept and reject together");
  a_busy_start: assert property ($rose(busy_o) |-> wb_ack_o)
    else $error("busy rose without a start");
  c_bcast: cover property (bus_bcast_o && bus_ready_i);
  c_accept: cover property (event_accept_o);
  c_done: cover property ($fell(busy_o));
endmodule : rsq_monitor
bind rsq_sequencer rsq_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .bus_ready_i(bus_ready_i),
  .bus_valid_o(bus_valid_o), .bus_write_o(bus_write_o), .bus_bcast_o(bus_bcast_o),
  .bus_word_o(bus_word_o), .first_level_trigger_o(first_level_trigger_o),
  .event_accept_o(event_accept_o), .event_reject_o(event_reject_o), .busy_o(busy_o));
`default_nettype wire

// >>> tb/test_readout_instruction_sequencer.sv
// testbench: scenario tasks for the readout instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module test_readout_instruction_sequencer;
  import rsq_pkg::*;
  localparam logic [4:0] ACMD = 5'h06;
  localparam logic [4:0] DCMD = 5'h07;
  localparam logic [4:0] SCMD = 5'h1B;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, l1 = 0, acc = 0, rej = 0, slow = 0;
  logic rdy, ack, valid, wr, bc, trig, evs, eva, evr, busy;
  logic [15:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [39:0] word;
  logic busy_d = 1'b0;
  logic [1:0] wbf = 2'h0;
  int error_cnt = 0, compares = 0, cnt = 0, t0 = 0, t1 = 0, a;
  int ev[4] = '{0, 0, 0, 0}, base[4];
  rsq_sequencer #(.PED_ADDR_CMD(ACMD), .PED_DATA_CMD(DCMD), .SOFT_TRIG_CMD(SCMD)) DUT (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus_ready_i(rdy),
    .bus_valid_o(valid), .bus_write_o(wr), .bus_bcast_o(bc), .bus_word_o(word),
    .ext_l1_i(l1), .second_level_accept_i(acc), .second_level_reject_i(rej), .first_level_trigger_o(trig),
    .event_start_o(evs), .event_accept_o(eva), .event_reject_o(evr), .busy_o(busy));
  rsq_fe_model fe (.clk_i(clk), .rst_i(rst), .slow_i(slow), .bus_valid_i(valid),
    .bus_word_i(word), .ready_o(rdy));
  initial forever #2.5 clk = ~clk;
  // pulse counters and timestamps; scenarios compare against a baseline
  always @(posedge clk) begin
    cnt <= cnt + 1;
    busy_d <= busy;
    if (busy && !busy_d) t0 <= cnt;
    if (valid && rdy) wbf <= {wr, bc}; // flags of the last word the front end took
    if (trig) t1 <= cnt;
    ev[0] <= ev[0] + int'(trig);
    ev[1] <= ev[1] + int'(evs);
    ev[2] <= ev[2] + int'(eva);
    ev[3] <= ev[3] + int'(evr);
  end
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk
  function automatic int d(input int k);
    return ev[k] - base[k];
  endfunction : d
  function automatic logic [39:0] pw(input logic b, input logic [11:0] ch,
                                     input logic [4:0] c, input logic [19:0] v);
    return {1'b0, b, ch, c, 1'b0, v};
  endfunction : pw
  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [15:0] ad, input logic [31:0] dt);
    int i;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= ad; wdat <= dt;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      chk(40'h1, 40'h0);
      tally_and_finish();
    end
    q = rdat;
    cyc <= 0; stb <= 0;
  endtask : wb
  task automatic rd(input logic [15:0] ad, input logic [31:0] e);
    wb(1'b0, ad, 32'h0);
    chk({8'h0, q}, {8'h0, e});
  endtask : rd
  task automatic ins(input int i, input logic [23:0] v);
    wb(1'b1, IMEM_BASE + 16'(4 * i), {8'h0, v});
  endtask : ins
  // start in a mode and wait, bounded, for the sequence to finish
  task automatic run(input logic [1:0] m);
    int i;
    base = ev;
    fe.words.delete();
    wb(1'b1, REG_CTRL, {29'h0, m, 1'b1});
    for (i = 0; i < 30000; i++) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    if (i == 30000) begin
      chk(40'h1, 40'h0);
      tally_and_finish();
    end
    repeat (4) @(posedge clk);
  endtask : run
  task automatic pul(input int k);
    @(posedge clk);
    {l1, acc, rej} <= 3'b100 >> k;
    @(posedge clk);
    {l1, acc, rej} <= 3'b000;
    repeat (3) @(posedge clk);
  endtask : pul
  task automatic t_regs();
    rd(REG_CTRL, 32'h0);
    rd(16'h0100, 32'h0);
    wb(1'b1, REG_CTRL, 32'h2);
    rd(REG_CTRL, 32'h0);
    wb(1'b1, REG_CTRL, 32'h6);
    rd(REG_CTRL, 32'h6);
  endtask : t_regs
  // broadcast block write over a two-entry range, partner stalling, then a full-memory non-broadcast write
  task automatic t_ped();
    ins(0, 24'h28CABC);
    ins(1, 24'h390000);
    wb(1'b1, REG_PRANGE, 32'h00060005);
    wb(1'b1, PMEM_BASE + 16'h0014, 32'h12345);
    wb(1'b1, PMEM_BASE + 16'h0018, 32'hABCDE);
    slow <= 1;
    run(2'h0);
    slow <= 0;
    chk(40'(fe.words.size()), 40'h4);
    chk(fe.words[0], pw(1'b1, 12'hABC, ACMD, 20'h5));
    chk(fe.words[1], pw(1'b1, 12'hABC, DCMD, 20'h12345));
    chk(fe.words[2], pw(1'b1, 12'hABC, ACMD, 20'h6));
    chk(fe.words[3], pw(1'b1, 12'hABC, DCMD, 20'hABCDE));
    chk(40'(wbf), 40'h3);
    ins(0, 24'h280123);
    run(2'h0);
    chk(40'(fe.words.size()), 40'h800);
    chk(fe.words[0], pw(1'b0, 12'h123, ACMD, 20'h0));
    chk(fe.words[2046], pw(1'b0, 12'h123, ACMD, 20'h3FF));
    chk(40'(wbf), 40'h2);
  endtask : t_ped
  task automatic t_seq();
    ins(0, 24'h390000);
    ins(1, 24'h3B0000);
    run(2'h0);
    chk(40'(d(0)), 40'h0);
    rd(REG_STATUS, 32'h0);
    ins(0, 24'h3A0003);
    ins(1, 24'h3B0000);
    ins(2, 24'h390000);
    run(2'h2);
    a = t1 - t0;
    chk(40'(d(0)), 40'h1);
    chk(40'(d(1)), 40'h1);
    ins(0, 24'h3A000A);
    run(2'h2);
    chk(40'(t1 - t0 - a), 40'h7);
    ins(0, 24'h3B0000);
    ins(1, 24'h308200);
    run(2'h0);
    chk(40'(d(0)), 40'h3);
    chk(40'(d(1)), 40'h0);
    ins(0, 24'h50001B);
    ins(1, 24'h390000);
    run(2'h0);
    chk(40'(d(1)), 40'h1);
    chk(fe.words[0], 40'h1B);
    chk(40'(wbf), 40'h0);
  endtask : t_seq
  // external first and second level triggers in modes 3 and 2
  task automatic t_ext();
    ins(0, 24'h390000);
    run(2'h3);
    pul(0);
    pul(1);
    pul(0);
    pul(2);
    chk(40'(d(1)), 40'h2);
    chk(40'(d(2)), 40'h1);
    chk(40'(d(3)), 40'h1);
    run(2'h2);
    pul(0);
    chk(40'(d(1)), 40'h1);
  endtask : t_ext
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_regs();
    t_ped();
    t_seq();
    t_ext();
    tally_and_finish();
  end
endmodule : test_readout_instruction_sequencer
`default_nettype wire
